// ==== rtl/arfl_pkg.sv ====
package arfl_pkg;
	// register byte offsets
	localparam logic [11:0] ARFL_OFS_SET = 12'h108; // write ones to enable nodes
	localparam logic [11:0] ARFL_OFS_CLR = 12'h10c; // write ones to disable nodes
	localparam logic [11:0] ARFL_OFS_CTRL = 12'h110; // remote-bus enable bit
	localparam logic [11:0] ARFL_OFS_STAT = 12'h114; // reject counter
	localparam logic [31:0] ARFL_MASK_RST = 32'h0000_0000; // mask reset value
	localparam logic [31:0] ARFL_ZERO = 32'h0000_0000; // unmapped read value
	localparam int ARFL_CTRL_REMOTE_BIT = 0; // position of remote-bus enable
	localparam logic [9:0] ARFL_LOCAL_BUS = 10'h3ff; // bus id meaning local bus
	localparam logic [5:0] ARFL_NODE_BROADCAST = 6'h3f; // node 63
	localparam logic [15:0] ARFL_CNT_ONE = 16'h0001; // counter step

	// destination context of a received request
	typedef enum logic [1:0] {
		ARFL_CTX_NONE = 2'b00,
		ARFL_CTX_PHYS = 2'b01,
		ARFL_CTX_ASYNC = 2'b10
	} arfl_ctx_e;

	// request presented by the receive path
	typedef struct packed {
		logic valid; // one-cycle strobe
		arfl_ctx_e ctx; // destination context
		logic [9:0] bus_id; // source bus
		logic [5:0] node_id; // source node
	} arfl_req_s;

	// decision back to the receive path
	typedef struct packed {
		logic valid; // one-cycle strobe
		logic accept; // acknowledge and queue
	} arfl_dec_s;
endpackage : arfl_pkg

// ==== rtl/arfl_check.sv ====
`timescale 1ns/100ps
// combinational acceptance decision for one request
module arfl_check
	import arfl_pkg::*;
(
	input wire arfl_req_s req,
	input wire logic [31:0] mask,
	input wire logic remote_en,
	input wire logic upper_hit,
	output logic hit,
	output logic checked
);
	// only requests bound for the two request contexts are checked
	always_comb begin
		checked = req.valid && (req.ctx == ARFL_CTX_PHYS || req.ctx == ARFL_CTX_ASYNC);
		hit = 1'b0;
		if (req.bus_id != ARFL_LOCAL_BUS) begin
			// foreign bus: per-node bits do not apply
			hit = remote_en;
		end else if (req.node_id[5]) begin
			// nodes 32 and above belong to the upper mask outside this block
			hit = upper_hit;
		end else begin
			hit = mask[req.node_id[4:0]];
		end
	end
endmodule : arfl_check

// ==== rtl/arfl_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// - 32-bit mask covers local nodes 0 to 31
// - bit n set accepts requests from node n
// - ones set at 108h, clear at 10Ch; resets zero
// - filters like the upper-node mask
// - check source of physical and async-context requests
// - masked node: no acknowledge, no queueing
// - remote bus accepted only with remote enable
module arfl_top
	import arfl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire arfl_req_s rx_req,
	input wire logic rx_upper_hit,
	output arfl_dec_s rx_dec,
	output logic [31:0] node_request_accept_bit
);
	// state and next values, grouped as bus side and filter side
	logic [31:0] mask_reg, mask_next; // per-node accept mask
	logic remote_reg, remote_next; // accept_remote_bus_requests
	logic [15:0] rej_cnt_reg, rej_cnt_next; // rejected requests, wraps
	logic [31:0] rdata_reg, rdata_next; // read data
	logic wait_reg, wait_next; // waitrequest
	arfl_dec_s dec_reg, dec_next; // decision output
	logic done_reg, done_next; // answer given this cycle
	logic [31:0] wmask; // byte-enable expanded write data
	logic hit;
	logic checked;

	// filter decision path
	arfl_check u_check (
		.req(rx_req),
		.mask(mask_reg),
		.remote_en(remote_reg),
		.upper_hit(rx_upper_hit),
		.hit(hit),
		.checked(checked)
	);

	// byte lanes: a disabled lane writes no ones, so it leaves bits alone
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = avs_byteenable[gi] ? avs_writedata[gi*8 +: 8] : 8'h00;
		end
	endgenerate

	// register file and bus answer; one wait cycle, then answer
	always_comb begin
		mask_next = mask_reg;
		remote_next = remote_reg;
		rdata_next = rdata_reg;
		wait_next = 1'b1;
		done_next = 1'b0;
		if ((avs_read || avs_write) && wait_reg && !done_reg) begin
			// accept on this edge; waitrequest falls next cycle
			wait_next = 1'b0;
			done_next = 1'b1;
			if (avs_write) begin
				case (avs_address)
					ARFL_OFS_SET: mask_next = mask_reg | wmask;
					ARFL_OFS_CLR: mask_next = mask_reg & ~wmask;
					ARFL_OFS_CTRL: begin
						if (avs_byteenable[0]) begin
							remote_next = avs_writedata[ARFL_CTRL_REMOTE_BIT];
						end
					end
					default: ; // unmapped writes ignored
				endcase
			end else begin
				case (avs_address)
					ARFL_OFS_SET, ARFL_OFS_CLR: rdata_next = mask_reg;
					ARFL_OFS_CTRL: rdata_next = {31'h0000_0000, remote_reg};
					ARFL_OFS_STAT: rdata_next = {16'h0000, rej_cnt_reg};
					default: rdata_next = ARFL_ZERO;
				endcase
			end
		end
	end

	// decision and reject count
	always_comb begin
		dec_next.valid = checked;
		dec_next.accept = checked && hit;
		rej_cnt_next = rej_cnt_reg;
		if (checked && !hit) begin
			rej_cnt_next = rej_cnt_reg + ARFL_CNT_ONE;
		end
	end

	// bus-side registers only; the pin copy takes mask_next so it never lags the mask
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_reg <= ARFL_MASK_RST;
			remote_reg <= 1'b0; // remote requests refused after reset
			rdata_reg <= ARFL_ZERO;
			wait_reg <= 1'b1; // bus parked busy
			done_reg <= 1'b0;
			node_request_accept_bit <= ARFL_MASK_RST;
		end else begin
			mask_reg <= mask_next;
			remote_reg <= remote_next;
			rdata_reg <= rdata_next;
			wait_reg <= wait_next;
			done_reg <= done_next;
			node_request_accept_bit <= mask_next;
		end
	end

	// filter-side registers only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rej_cnt_reg <= 16'h0000;
			dec_reg <= '0; // no stray decision out of reset
		end else begin
			rej_cnt_reg <= rej_cnt_next;
			dec_reg <= dec_next;
		end
	end

	// outputs leave straight from their flops
	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign rx_dec = dec_reg;

	// a set write lands one cycle after the accepting edge
	set_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(avs_write && wait_reg && !done_reg && avs_address == ARFL_OFS_SET
			&& avs_byteenable == 4'hf)
		|=> ((mask_reg & $past(avs_writedata)) == $past(avs_writedata)))
		else $error("set write did not set mask bits");
	clr_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(avs_write && wait_reg && !done_reg && avs_address == ARFL_OFS_CLR
			&& avs_byteenable == 4'hf)
		|=> ((mask_reg & $past(avs_writedata)) == 32'h0000_0000))
		else $error("clear write did not clear mask bits");
	mask_read_a: assert property (@(posedge core_clk) disable iff (rst)
		(avs_read && wait_reg && !done_reg
			&& (avs_address == ARFL_OFS_SET || avs_address == ARFL_OFS_CLR))
		|=> (!avs_waitrequest && avs_readdata == $past(mask_reg) && $stable(mask_reg)))
		else $error("mask read wrong");
	local_node_a: assert property (@(posedge core_clk) disable iff (rst)
		(rx_req.valid && (rx_req.ctx == ARFL_CTX_PHYS || rx_req.ctx == ARFL_CTX_ASYNC)
			&& rx_req.bus_id == ARFL_LOCAL_BUS && !rx_req.node_id[5])
		|=> (rx_dec.accept == $past(mask_reg[rx_req.node_id[4:0]])))
		else $error("local node decision wrong");
	reject_node_a: assert property (@(posedge core_clk) disable iff (rst)
		(rx_dec.valid && !rx_dec.accept) |-> (rej_cnt_reg == $past(rej_cnt_reg) + ARFL_CNT_ONE))
		else $error("reject not counted");
	remote_bus_a: assert property (@(posedge core_clk) disable iff (rst)
		(rx_req.valid && (rx_req.ctx == ARFL_CTX_PHYS || rx_req.ctx == ARFL_CTX_ASYNC)
			&& rx_req.bus_id != ARFL_LOCAL_BUS)
		|=> (rx_dec.accept == $past(remote_reg)))
		else $error("remote bus decision wrong");
	ctx_check_a: assert property (@(posedge core_clk) disable iff (rst)
		!(rx_req.valid && (rx_req.ctx == ARFL_CTX_PHYS || rx_req.ctx == ARFL_CTX_ASYNC))
		|=> !rx_dec.valid)
		else $error("unchecked context produced decision");
	upper_node_a: assert property (@(posedge core_clk) disable iff (rst)
		(rx_req.valid && (rx_req.ctx == ARFL_CTX_PHYS || rx_req.ctx == ARFL_CTX_ASYNC)
			&& rx_req.bus_id == ARFL_LOCAL_BUS && rx_req.node_id[5])
		|=> (rx_dec.accept == $past(rx_upper_hit)))
		else $error("upper node decision wrong");
	mask_out_a: assert property (@(posedge core_clk) disable iff (rst)
		##1 node_request_accept_bit == mask_reg)
		else $error("mask output mismatch");

	// every mask bit outside a taken set or clear write holds still
	mask_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		!(avs_write && wait_reg && !done_reg
			&& (avs_address == ARFL_OFS_SET || avs_address == ARFL_OFS_CLR))
		|=> $stable(mask_reg))
		else $error("mask changed without a set or clear write");
	// zero bits in a set write leave enabled nodes enabled
	set_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		(avs_write && wait_reg && !done_reg && avs_address == ARFL_OFS_SET)
		|=> ((mask_reg & $past(mask_reg)) == $past(mask_reg)))
		else $error("set write cleared mask bits");
	// zero bits in a clear write leave disabled nodes disabled
	clr_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		(avs_write && wait_reg && !done_reg && avs_address == ARFL_OFS_CLR)
		|=> ((mask_reg & ~$past(mask_reg)) == ARFL_ZERO))
		else $error("clear write set mask bits");
	// the mask leaves reset cleared, so no local node 0 to 31 and no remote-bus node is accepted by default
	mask_reset_a: assert property (@(posedge core_clk) disable iff (rst)
		$fell(rst) |-> (mask_reg == ARFL_MASK_RST && !remote_reg))
		else $error("mask not cleared by reset");
	// the pin copy follows set bits, lane gating included
	out_set_a: assert property (@(posedge core_clk) disable iff (rst)
		(avs_write && wait_reg && !done_reg && avs_address == ARFL_OFS_SET)
		|=> ((node_request_accept_bit & $past(wmask)) == $past(wmask)))
		else $error("accept bits missed a set write");
	// a control write moves the remote-bus enable
	ctrl_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(avs_write && wait_reg && !done_reg && avs_address == ARFL_OFS_CTRL
			&& avs_byteenable[0])
		|=> (remote_reg == $past(avs_writedata[ARFL_CTRL_REMOTE_BIT])))
		else $error("remote enable not written");
	// each taken request is answered after exactly one wait cycle
	bus_answer_a: assert property (@(posedge core_clk) disable iff (rst)
		((avs_read || avs_write) && wait_reg && !done_reg) |=> !avs_waitrequest)
		else $error("bus request not answered");
	// the answer stands one cycle, so a held request is never taken twice
	wait_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	// every checked request gets a decision one cycle later
	dec_valid_a: assert property (@(posedge core_clk) disable iff (rst)
		(rx_req.valid && (rx_req.ctx == ARFL_CTX_PHYS || rx_req.ctx == ARFL_CTX_ASYNC))
		|=> rx_dec.valid)
		else $error("checked request got no decision");
	// the reject count moves only on a refused request
	rej_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		(!$past(rst) && !(rx_dec.valid && !rx_dec.accept)) |-> $stable(rej_cnt_reg))
		else $error("reject count moved without a refusal");
endmodule : arfl_top

// ==== bench/arfl_tb_top.sv ====
`timescale 1ns/100ps
// register and filter bench for the lower-node request mask
module arfl_tb_top
	import arfl_pkg::*;
;
	logic core_clk, rst; // clock and sync reset
	logic [11:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, q, node_request_accept_bit;
	logic [3:0] avs_byteenable;
	arfl_req_s rx_req; // request from receive path
	logic rx_upper_hit;
	arfl_dec_s rx_dec;
	int n_mismatch, checks, cyc; // report counters, hang guard
	arfl_top arfl_top_inst (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_req(rx_req), .rx_upper_hit(rx_upper_hit),
		.rx_dec(rx_dec), .node_request_accept_bit(node_request_accept_bit));
	// 125 MHz clock
	always #4 core_clk = ~core_clk;
	// verdict, single exit point
	task automatic results();
		if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	// hang guard, far above the fewer than one hundred cycles needed
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			results();
		end
	end
	// one compare for all values, an unknown matches only an unknown
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// one bus word; held until waitrequest is seen low at an edge
	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk); // keeps release and next request apart
	endtask : bus
	// one filter request; decision expected one cycle after it is taken
	task automatic req(input arfl_ctx_e c, input logic [9:0] b, input logic [5:0] n,
		input logic up, input logic ev, input logic ea);
		rx_req <= '{1'b1, c, b, n};
		rx_upper_hit <= up;
		@(posedge core_clk);
		rx_req.valid <= 1'b0;
		@(posedge core_clk);
		chk("dec_valid", {31'h0, ev}, {31'h0, rx_dec.valid});
		if (ev) chk("dec_accept", {31'h0, ea}, {31'h0, rx_dec.accept});
	endtask : req
	// main sequence
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		avs_address = 12'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = ARFL_ZERO;
		avs_byteenable = 4'hf; // full words unless a lane test says otherwise
		rx_req = '0;
		rx_upper_hit = 1'b0;
		n_mismatch = 0;
		checks = 0;
		cyc = 0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, ARFL_OFS_SET, ARFL_ZERO);
		chk("mask_reset", ARFL_MASK_RST, q);
		chk("accept_bits", ARFL_MASK_RST, node_request_accept_bit);
		bus(1'b1, ARFL_OFS_SET, 32'h8000_0009);
		bus(1'b0, ARFL_OFS_CLR, ARFL_ZERO);
		chk("read_clr", 32'h8000_0009, q);
		bus(1'b0, ARFL_OFS_SET, ARFL_ZERO);
		chk("read_set", 32'h8000_0009, q);
		bus(1'b1, ARFL_OFS_CLR, 32'h0000_0008);
		bus(1'b0, ARFL_OFS_SET, ARFL_ZERO);
		chk("after_clr", 32'h8000_0001, q);
		chk("accept_bits", 32'h8000_0001, node_request_accept_bit);
		bus(1'b0, 12'h1f0, ARFL_ZERO);
		chk("unmapped", ARFL_ZERO, q);
		req(ARFL_CTX_ASYNC, ARFL_LOCAL_BUS, 6'h00, 1'b0, 1'b1, 1'b1);
		req(ARFL_CTX_ASYNC, ARFL_LOCAL_BUS, 6'h03, 1'b0, 1'b1, 1'b0);
		req(ARFL_CTX_PHYS, ARFL_LOCAL_BUS, 6'h1f, 1'b0, 1'b1, 1'b1);
		req(ARFL_CTX_NONE, ARFL_LOCAL_BUS, 6'h00, 1'b0, 1'b0, 1'b0);
		req(ARFL_CTX_ASYNC, ARFL_LOCAL_BUS, 6'h28, 1'b1, 1'b1, 1'b1);
		req(ARFL_CTX_ASYNC, ARFL_LOCAL_BUS, 6'h28, 1'b0, 1'b1, 1'b0);
		req(ARFL_CTX_ASYNC, 10'h001, 6'h00, 1'b0, 1'b1, 1'b0);
		bus(1'b1, ARFL_OFS_CTRL, 32'h0000_0001);
		req(ARFL_CTX_ASYNC, 10'h001, 6'h05, 1'b0, 1'b1, 1'b1);
		bus(1'b0, ARFL_OFS_CTRL, ARFL_ZERO);
		chk("remote_en", 32'h0000_0001, q);
		bus(1'b0, ARFL_OFS_STAT, ARFL_ZERO);
		chk("reject_count", 32'h0000_0003, q);
		avs_byteenable <= 4'h1; // only the low lane may set bits
		bus(1'b1, ARFL_OFS_SET, 32'hffff_ff10);
		avs_byteenable <= 4'hf;
		bus(1'b0, ARFL_OFS_SET, ARFL_ZERO);
		chk("lane_set", 32'h8000_0011, q);
		// a reset in mid-run must clear a populated mask and the remote enable
		rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, ARFL_OFS_CLR, ARFL_ZERO);
		chk("mask_rerst", ARFL_MASK_RST, q);
		chk("accept_rerst", ARFL_MASK_RST, node_request_accept_bit);
		req(ARFL_CTX_ASYNC, ARFL_LOCAL_BUS, 6'h00, 1'b0, 1'b1, 1'b0);
		req(ARFL_CTX_ASYNC, 10'h001, 6'h05, 1'b0, 1'b1, 1'b0);
		results();
	end
endmodule : arfl_tb_top
